/* File: asp_pkg.sv */
/*
  Constants for the asynchronous serial port: register offsets, field
  positions, reset values, mode codes and divider figures.
  Assumes a 32-bit classic Wishbone register bus, one register per word.
*/
package asp_pkg;
  // Register byte offsets.
  localparam logic [4:0] ASP_OFS_MODE  = 5'h00;
  localparam logic [4:0] ASP_OFS_CTL0  = 5'h04;
  localparam logic [4:0] ASP_OFS_CTL1  = 5'h08;
  localparam logic [4:0] ASP_OFS_BRG   = 5'h0c;
  localparam logic [4:0] ASP_OFS_TBUF  = 5'h10;
  localparam logic [4:0] ASP_OFS_RBUF  = 5'h14;
  localparam logic [4:0] ASP_OFS_IREQ  = 5'h18;
  // Frame mode fields.
  localparam int ASP_MODE_EXTCLK = 3;
  localparam int ASP_MODE_STOP2  = 4;
  localparam int ASP_MODE_EVEN   = 5;
  localparam int ASP_MODE_PAREN  = 6;
  localparam int ASP_MODE_SLEEP  = 7;
  localparam logic [2:0] ASP_ASYNC7 = 3'h4;
  localparam logic [2:0] ASP_ASYNC8 = 3'h5;
  localparam logic [2:0] ASP_ASYNC9 = 3'h6;
  // Control zero fields.
  localparam int ASP_C0_RTSSEL = 2;
  localparam int ASP_C0_TXC    = 3;
  // Control one fields.
  localparam int ASP_C1_TE  = 0;
  localparam int ASP_C1_TBE = 1;
  localparam int ASP_C1_RE  = 2;
  localparam int ASP_C1_RXF = 3;
  localparam int ASP_C1_OVR = 4;
  localparam int ASP_C1_FER = 5;
  localparam int ASP_C1_PER = 6;
  localparam int ASP_C1_SUM = 7;
  // Reset values.
  localparam logic [7:0] ASP_MODE_RST = 8'h00;
  localparam logic [7:0] ASP_BRG_RST  = 8'h00;
  // Internal source prescaler taps (divide by 8, 32, 512).
  localparam int ASP_PRE_W = 9;
  localparam int ASP_TAP1  = 3;
  localparam int ASP_TAP2  = 5;
  localparam int ASP_TAP3  = 9;
  // Sixteen divided-clock periods per bit, sampled in the middle.
  localparam logic [3:0] ASP_SUB_LAST = 4'hf;
  localparam logic [3:0] ASP_SUB_MID  = 4'h7;
  localparam int ASP_FRAME_W = 13;
endpackage

/* File: asp_serial_peer.sv */
/*
  Serial partner model: a second asynchronous port on the line.
  Assumes the bench clock and a fixed bit period in clock cycles.
*/
`timescale 1ns/100ps
module asp_serial_peer
  import asp_pkg::*;
#(
  parameter int BIT_CYC = 16
) (
  // Clock and line.
  input  wire logic                   clk_i,
  input  wire logic                   line_i,
  output logic                        line_o,
  // Captured frame.
  output logic [ASP_FRAME_W-1:0]      frame_o,
  output int                          count_o
);
  // The line rests high between frames.
  initial begin
    line_o  = 1'b1;
    count_o = 0;
  end
  // mid-bit sampling
  // Captures all bit slots after a falling edge, each in mid-bit.
  always begin
    @(negedge line_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < ASP_FRAME_W; i++) begin
      frame_o[i] = line_i;
      repeat (BIT_CYC) @(posedge clk_i);
    end
    count_o++;
  end
  // whole frame
  // Sends one frame, one bit period a slot, then idles the line high.
  task automatic send(input logic [ASP_FRAME_W-1:0] f, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    line_o <= 1'b1;
  endtask
endmodule

/* File: asp_top.sv */
/*
  One channel of an asynchronous serial port with Wishbone registers.
  Assumes a classic Wishbone master on clk_i, a serial partner on rxd/txd
  and an optional handshake pin driven through the enable given here.
*/
// Local design decisions: register access over Wishbone and the address map.
// What this block does
// - Frames of 7, 8 or 9 data bits.
// - Mode bits 2..0 equal 101 selects 8-bit.
// - Mode bit 3 picks external clock pin.
// - Clock divided by n plus one, sixteen.
// - Mode bit 4 selects two stop bits.
// - Mode bits 5, 6 pick parity sense, presence.
// - Mode bit 7 enables sleep mode.
// - Control zero bit 2 selects request-to-send.
// - Start needs enable, full buffer, clear-to-send unless request-to-send is selected.
// - Data leaves least significant bit first.
// - Buffer write clears, load sets empty flag.
// - Running frame ignores enable and handshake.
// - Next word written before end-of-frame rises.
// - Complete flag follows end-of-frame, cleared on start.
// - Empty flag rise sets transmit request.
// - Receive enable; divider restarts on start bit.
// - Request-to-send follows enable and reception.
// - Frame end fills buffer, sets full flag.
// - Overrun when full flag still set.
// - Framing, parity and summary error flags.
// - Flags set at transfer, cleared by read.
// - Sleep discards words with top bit zero.
`timescale 1ns/100ps
module asp_top
  import asp_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial pins.
  input  wire logic        rxd_i,
  output logic             txd_o,
  input  wire logic        ext_clk_i,
  input  wire logic        hs_i,
  output logic             hs_o,
  output logic             hs_oe_o
);
  typedef enum logic {ASP_TX_IDLE = 1'b0, ASP_TX_SEND = 1'b1} asp_tx_e;
  typedef enum logic {ASP_RX_IDLE = 1'b0, ASP_RX_RUN = 1'b1} asp_rx_e;

  logic [1:0] rst_q;
  logic rst_n;
  logic [7:0] mode, brg;
  logic [2:0] ctl0;
  logic te, re, tbe, txc, rxf, ovr, fer, per, ireq_tx, ireq_rx;
  logic [8:0] tbuf, rbuf;
  logic [2:0] rx_s, ck_s, hs_s;
  logic rx_lvl, ck_lvl, hs_lvl;
  logic [ASP_PRE_W-1:0] pre_cnt;
  logic [7:0] brg_cnt;
  logic pre_en, tick;
  logic hit, wr, rd, async_on, go, tx_load, tx_bit_end, tx_eof, eof_q, rts;
  logic [3:0] dlen, tx_sub, rx_sub, tx_left, rx_idx, rx_total;
  logic [ASP_FRAME_W-1:0] tx_sr, next_frame, rx_fr;
  asp_tx_e tx_st;
  asp_rx_e rx_st;
  logic rx_samp, rx_done, rx_xfer, rx_top, rx_pe, rx_fe;
  logic [8:0] rx_data;

  // Reset is released through two flip-flops.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Pin synchronisers; a level counts once stages two and three agree.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_s <= 3'h7;
      ck_s <= 3'h0;
      hs_s <= 3'h7;
      rx_lvl <= 1'b1;
      ck_lvl <= 1'b0;
      hs_lvl <= 1'b1;
    end else begin
      rx_s <= {rx_s[1:0], rxd_i};
      ck_s <= {ck_s[1:0], ext_clk_i};
      hs_s <= {hs_s[1:0], hs_i};
      if (rx_s[1] == rx_s[2]) rx_lvl <= rx_s[2];
      if (ck_s[1] == ck_s[2]) ck_lvl <= ck_s[2];
      if (hs_s[1] == hs_s[2]) hs_lvl <= hs_s[2];
    end
  end

  always_comb begin
    async_on = 1'b1;
    unique case (mode[2:0])
      ASP_ASYNC7: dlen = 4'h7;
      ASP_ASYNC8: dlen = 4'h8;
      ASP_ASYNC9: dlen = 4'h9;
      default: begin
        dlen = 4'h8;
        async_on = 1'b0;
      end
    endcase
  end

  // Free prescaler giving the internal source taps.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) pre_cnt <= '0;
    else pre_cnt <= pre_cnt + 1'b1;
  end

  // source select, internal taps or external clock rising edge.
  always_comb begin
    if (mode[ASP_MODE_EXTCLK]) begin
      pre_en = ck_s[2] && ck_s[1] && !ck_lvl;
    end else begin
      unique case (ctl0[1:0])
        2'h0: pre_en = 1'b1;
        2'h1: pre_en = (pre_cnt[ASP_TAP1-1:0] == '0);
        2'h2: pre_en = (pre_cnt[ASP_TAP2-1:0] == '0);
        2'h3: pre_en = (pre_cnt[ASP_TAP3-1:0] == '0);
      endcase
    end
  end

  // divide by n plus one; the sixteen is counted per bit.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      brg_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre_en) begin
        if (brg_cnt == 8'h00) begin
          brg_cnt <= brg;
          tick <= 1'b1;
        end else begin
          brg_cnt <= brg_cnt - 1'b1;
        end
      end
    end
  end

  // Bus request decode; every access is acknowledged one cycle later.
  assign hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = hit && wb_we_i;
  assign rd = hit && !wb_we_i;

  // Software-owned configuration registers.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode <= ASP_MODE_RST;
      brg <= ASP_BRG_RST;
      ctl0 <= 3'h0;
      te <= 1'b0;
      re <= 1'b0;
      tbuf <= 9'h000;
    end else if (wr) begin
      if (wb_adr_i == ASP_OFS_MODE && wb_sel_i[0]) mode <= wb_dat_i[7:0];
      if (wb_adr_i == ASP_OFS_BRG && wb_sel_i[0]) brg <= wb_dat_i[7:0];
      if (wb_adr_i == ASP_OFS_CTL0 && wb_sel_i[0]) ctl0 <= wb_dat_i[2:0];
      if (wb_adr_i == ASP_OFS_CTL1 && wb_sel_i[0]) begin
        te <= wb_dat_i[ASP_C1_TE];
        re <= wb_dat_i[ASP_C1_RE];
      end
      if (wb_adr_i == ASP_OFS_TBUF && wb_sel_i[0]) tbuf[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == ASP_OFS_TBUF && wb_sel_i[1]) tbuf[8] <= wb_dat_i[8];
    end
  end

  // start condition; clear-to-send only counts when request-to-send is not selected.
  assign go = async_on && te && !tbe && (ctl0[ASP_C0_RTSSEL] || !hs_lvl);
  assign tx_bit_end = tick && (tx_sub == ASP_SUB_LAST);
  assign tx_eof = (tx_st == ASP_TX_SEND) && (tx_left == 4'h1);
  // next word is taken at the end of the last stop bit.
  // An idle start waits for a divider tick so that the start bit lasts a full period.
  assign tx_load = go && (((tx_st == ASP_TX_IDLE) && tick) || (tx_eof && tx_bit_end));

  // frame image: start, data from bit 0, parity, stops.
  always_comb begin
    next_frame = '1;
    next_frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(dlen)) next_frame[i+1] = tbuf[i];
    end
    if (mode[ASP_MODE_PAREN]) begin
      next_frame[dlen+4'h1] = ^(tbuf & ~(9'h1ff << dlen)) ^ !mode[ASP_MODE_EVEN];
    end
  end

  // a running frame only ends at its last bit.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_st <= ASP_TX_IDLE;
      tx_sr <= '1;
      tx_sub <= 4'h0;
      tx_left <= 4'h0;
      txd_o <= 1'b1;
    end else if (tx_load) begin
      tx_st <= ASP_TX_SEND;
      tx_sr <= next_frame;
      tx_sub <= 4'h0;
      tx_left <= 4'h2 + dlen + {3'h0, mode[ASP_MODE_PAREN]} + {3'h0, mode[ASP_MODE_STOP2]};
      txd_o <= 1'b0;
    end else if (tx_st == ASP_TX_SEND && tick) begin
      tx_sub <= tx_sub + 1'b1;
      if (tx_bit_end) begin
        tx_sr <= {1'b1, tx_sr[ASP_FRAME_W-1:1]};
        txd_o <= tx_sr[1];
        tx_left <= tx_left - 1'b1;
        if (tx_eof) begin
          tx_st <= ASP_TX_IDLE;
          txd_o <= 1'b1;
        end
      end
    end
  end

  // empty flag, complete flag and transmit request.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tbe <= 1'b1;
      txc <= 1'b1;
      eof_q <= 1'b0;
      ireq_tx <= 1'b0;
    end else begin
      eof_q <= tx_eof;
      if (tx_load) tbe <= 1'b1;
      else if (wr && wb_adr_i == ASP_OFS_TBUF && wb_sel_i[0]) tbe <= 1'b0;
      if (tx_load) txc <= 1'b0;
      else if (tx_eof && !eof_q) txc <= 1'b1;
      if (tx_load && !tbe) ireq_tx <= 1'b1;
      else if (wr && wb_adr_i == ASP_OFS_IREQ && wb_dat_i[0]) ireq_tx <= 1'b0;
    end
  end

  // sample point in the middle of each bit.
  assign rx_samp = (rx_st == ASP_RX_RUN) && tick && (rx_sub == ASP_SUB_MID);
  assign rx_total = 4'h2 + dlen + {3'h0, mode[ASP_MODE_PAREN]} + {3'h0, mode[ASP_MODE_STOP2]};
  assign rx_done = rx_samp && (rx_idx == rx_total - 4'h1);

  // unpack the captured frame and check parity and stops.
  always_comb begin
    rx_data = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(dlen)) rx_data[i] = rx_fr[i+1];
    end
    rx_top = rx_data[dlen-4'h1];
    rx_pe = mode[ASP_MODE_PAREN] && ((^rx_data ^ rx_fr[dlen+4'h1]) == mode[ASP_MODE_EVEN]);
    rx_fe = !rx_lvl;
    if (mode[ASP_MODE_STOP2]) rx_fe = rx_fe || !rx_fr[rx_total-4'h2];
  end
  // sleep mode drops words whose top bit is zero.
  assign rx_xfer = rx_done && !(mode[ASP_MODE_SLEEP] && !rx_top);

  // receiver; the bit divider restarts at each start edge.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_st <= ASP_RX_IDLE;
      rx_sub <= 4'h0;
      rx_idx <= 4'h0;
      rx_fr <= '1;
    end else if (!re || !async_on) begin
      rx_st <= ASP_RX_IDLE;
    end else if (rx_st == ASP_RX_IDLE) begin
      if (!rx_lvl && rx_s[2] == 1'b0 && rx_s[1] == 1'b0 && rx_fr[0]) begin
        rx_st <= ASP_RX_RUN;
        rx_sub <= 4'h0;
        rx_idx <= 4'h0;
      end
      rx_fr[0] <= rx_lvl;
    end else if (tick) begin
      rx_sub <= rx_sub + 1'b1;
      if (rx_samp) begin
        rx_fr[rx_idx] <= rx_lvl;
        rx_idx <= rx_idx + 1'b1;
        if (rx_done || (rx_idx == 4'h0 && rx_lvl)) begin
          rx_st <= ASP_RX_IDLE;
          rx_fr[0] <= rx_lvl;
        end
      end
    end
  end

  // receive buffer and flags; a transfer beats a clear.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rbuf <= 9'h000;
      rxf <= 1'b0;
      ovr <= 1'b0;
      fer <= 1'b0;
      per <= 1'b0;
      ireq_rx <= 1'b0;
    end else begin
      if (rx_xfer) begin
        rbuf <= rx_data;
        rxf <= 1'b1;
        ovr <= rxf;
        fer <= rx_fe;
        per <= rx_pe;
        if (!rxf) ireq_rx <= 1'b1;
      end else if (!re || (rd && wb_adr_i == ASP_OFS_RBUF && wb_sel_i[0])) begin
        rxf <= 1'b0;
        ovr <= 1'b0;
        fer <= 1'b0;
        per <= 1'b0;
      end
      if (!(rx_xfer && !rxf) && wr && wb_adr_i == ASP_OFS_IREQ && wb_dat_i[1]) ireq_rx <= 1'b0;
    end
  end

  // request-to-send: high when disabled or receiving, low when ready.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rts <= 1'b1;
    end else if (!re) begin
      rts <= 1'b1;
    end else if (rx_done) begin
      rts <= 1'b0;
    end else if (rx_st == ASP_RX_RUN) begin
      rts <= 1'b1;
    end else if (rx_st == ASP_RX_IDLE && !rxf) begin
      rts <= 1'b0;
    end
  end

  // Pin drivers and bus answer, all registered.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hs_o <= 1'b1;
      hs_oe_o <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      hs_o <= rts;
      hs_oe_o <= ctl0[ASP_C0_RTSSEL];
      wb_ack_o <= hit;
      wb_dat_o <= 32'h0000_0000;
      if (rd) begin
        unique case (wb_adr_i)
          ASP_OFS_MODE: wb_dat_o[7:0] <= mode;
          ASP_OFS_CTL0: wb_dat_o[3:0] <= {txc, ctl0};
          ASP_OFS_CTL1: wb_dat_o[7:0] <= {ovr | fer | per, per, fer, ovr, rxf, re, tbe, te};
          ASP_OFS_BRG:  wb_dat_o[7:0] <= brg;
          ASP_OFS_TBUF: wb_dat_o[8:0] <= tbuf;
          ASP_OFS_RBUF: wb_dat_o[8:0] <= rbuf;
          ASP_OFS_IREQ: wb_dat_o[1:0] <= {ireq_rx, ireq_tx};
          default:      wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking asp_cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  AST_TX_START: assert property (tx_load |-> te && !tbe && (ctl0[ASP_C0_RTSSEL] || !hs_lvl))
    else $error("Frame started without its start condition.");
  AST_TBE_CLEAR: assert property ((wr && wb_adr_i == ASP_OFS_TBUF && wb_sel_i[0] && !tx_load) |=> !tbe)
    else $error("Buffer write did not clear empty flag.");
  AST_TX_HOLD: assert property ((tx_st == ASP_TX_SEND && !(tx_eof && tx_bit_end)) |=> tx_st == ASP_TX_SEND)
    else $error("Frame stopped before its last bit.");
  AST_TXC_SET: assert property ((tx_eof && !eof_q && !tx_load) |=> txc)
    else $error("Complete flag late after end of frame.");
  AST_TX_IRQ: assert property ($rose(tbe) |-> ireq_tx)
    else $error("Empty flag rise without transmit request.");
  AST_OVERRUN: assert property ((rx_xfer && rxf) |=> ovr && rxf)
    else $error("Overrun not flagged.");
  AST_RD_CLEAR: assert property ((rd && wb_adr_i == ASP_OFS_RBUF && wb_sel_i[0] && !rx_xfer) |=> !rxf && !ovr)
    else $error("Buffer read did not clear receive flags.");
  AST_SLEEP: assert property ((rx_done && mode[ASP_MODE_SLEEP] && !rx_top) |=> $stable(rxf) && $stable(rbuf))
    else $error("Sleep mode accepted a word with top bit zero.");
  AST_RTS_OFF: assert property ((!re ##1 !re) |=> hs_o)
    else $error("Request-to-send low while receive disabled.");
  COV_TX: cover property (tx_load ##[1:1000] tx_eof);
  COV_RX: cover property (rx_xfer);
  COV_OVR: cover property (rx_xfer && rxf);
endmodule

/* File: async_serial_port_test.sv */
/*
  Self-checking bench for the serial port: register traffic over Wishbone
  and frames exchanged with the partner model. Assumes the fastest rate.
*/
`timescale 1ns/100ps
module async_serial_port_test;
  import asp_pkg::*;
  // Bench signals.
  logic        clk_i, arst_n_i, cyc, stb, we, ack, txd, rxd, hs, hs_o, hs_oe;
  logic [4:0]  adr;
  logic [31:0] dat, dat_o, q;
  logic [12:0] pf;
  logic [1:0]  ec = 2'h0;
  logic [7:0]  mt [3] = '{8'h14, 8'h46, 8'h25};
  logic [8:0]  dt [3] = '{9'h05b, 9'h1b3, 9'h0ff};
  int          pc, len, m, n, err_count, checked;

  asp_top asp_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .rxd_i(rxd), .txd_o(txd), .ext_clk_i(ec[1]), .hs_i(hs), .hs_o(hs_o),
    .hs_oe_o(hs_oe));
  asp_serial_peer #(.BIT_CYC(16)) asp_serial_peer_i (.clk_i(clk_i), .line_i(txd),
    .line_o(rxd), .frame_o(pf), .count_o(pc));

  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Prints the counts and the verdict.
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One classic Wishbone cycle; ack and read data are taken at the same rising edge.
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      err_count++;
      end_of_test();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Reads a register and compares it.
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Builds a frame slot by slot, padded with idle ones.
  function automatic logic [12:0] frm(input logic [7:0] md, input logic [8:0] d, output int ln);
    int nb, p;
    logic par;
    nb = (md[2:0] == ASP_ASYNC7) ? 7 : (md[2:0] == ASP_ASYNC8) ? 8 : 9;
    frm = '1;
    frm[0] = 1'b0;
    par = ~md[ASP_MODE_EVEN];
    p = 1;
    for (int i = 0; i < nb; i++) begin
      frm[p] = d[i];
      par ^= d[i];
      p++;
    end
    if (md[ASP_MODE_PAREN]) begin
      frm[p] = par;
      p++;
    end
    ln = p + 1 + int'(md[ASP_MODE_STOP2]);
  endfunction
  // Waits, bounded, for the partner to capture a frame.
  task automatic wait_tx;
    int c, k;
    c = pc;
    k = 0;
    while (pc == c && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 4000) begin
      err_count++;
      end_of_test();
    end
  endtask
  // Partner sends a frame, optionally corrupted; control one is then read.
  task automatic rx(input logic [7:0] md, input logic [8:0] d, input logic [12:0] fl,
                    input logic [31:0] c1);
    logic [12:0] f;
    f = frm(md, d, len) ^ fl;
    asp_serial_peer_i.send(f, len);
    repeat (24) @(posedge clk_i);
    rd_chk(ASP_OFS_CTL1, c1);
  endtask

  // Free-running bench clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // External bit source: one rising edge every four clock cycles.
  always @(posedge clk_i) begin
    ec <= ec + 2'h1;
  end
  // Cuts a hang short.
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    arst_n_i = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 5'h00; dat = 32'h0; hs = 1'b1;
    err_count = 0;
    checked = 0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_chk(ASP_OFS_MODE, {24'h0, ASP_MODE_RST});
    rd_chk(ASP_OFS_BRG, {24'h0, ASP_BRG_RST});
    rd_chk(5'h1c, 32'h0);
    wb(1'b1, ASP_OFS_MODE, 32'h65);
    wb(1'b1, ASP_OFS_CTL0, 32'h0);
    wb(1'b1, ASP_OFS_CTL1, 32'h1);
    wb(1'b1, ASP_OFS_TBUF, 32'ha5);
    rd_chk(ASP_OFS_CTL1, 32'h1);
    chk(hs_oe, 1'b0);
    repeat (40) @(posedge clk_i);
    chk(txd, 1'b1);
    hs <= 1'b0;
    wait_tx();
    chk(pf, frm(8'h65, 9'h0a5, len));
    rd_chk(ASP_OFS_CTL0, 32'h8);
    rd_chk(ASP_OFS_IREQ, 32'h1);
    wb(1'b1, ASP_OFS_IREQ, 32'h1);
    rd_chk(ASP_OFS_IREQ, 32'h0);
    // Each length, odd or no parity, one or two stop bits; enable dropped in mid-frame.
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, ASP_OFS_MODE, {24'h0, mt[k]});
      wb(1'b1, ASP_OFS_CTL1, 32'h1);
      wb(1'b1, ASP_OFS_TBUF, {23'h0, dt[k]});
      repeat (30) @(posedge clk_i);
      wb(1'b1, ASP_OFS_CTL1, 32'h0);
      rd_chk(ASP_OFS_CTL0, 32'h0);
      wait_tx();
      chk(pf, frm(mt[k], dt[k], len));
    end
    // Start plus eight zero bits stay low 9*16 ticks: n=1 gives 288 cycles,
    // the external source with one edge every four cycles and n=0 gives 576.
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, ASP_OFS_BRG, (k == 0) ? 32'h1 : 32'h0);
      wb(1'b1, ASP_OFS_MODE, (k == 0) ? 32'h5 : 32'hd);
      wb(1'b1, ASP_OFS_CTL1, 32'h1);
      wb(1'b1, ASP_OFS_TBUF, 32'h0);
      n = 0;
      m = 0;
      while (txd !== 1'b0 && n < 100) begin
        @(negedge clk_i);
        n++;
      end
      while (txd === 1'b0 && m < 1000) begin
        @(negedge clk_i);
        m++;
      end
      chk(m, (k == 0) ? 288 : 576);
      repeat (700) @(posedge clk_i);
    end
    wb(1'b1, ASP_OFS_BRG, 32'h0);
    // Reception with request-to-send selected.
    wb(1'b1, ASP_OFS_CTL1, 32'h0);
    wb(1'b1, ASP_OFS_CTL0, 32'h4);
    wb(1'b1, ASP_OFS_MODE, 32'h65);
    wb(1'b1, ASP_OFS_IREQ, 32'h3);
    chk(hs_oe, 1'b1);
    chk(hs_o, 1'b1);
    wb(1'b1, ASP_OFS_CTL1, 32'h4);
    repeat (3) @(posedge clk_i);
    chk(hs_o, 1'b0);
    rx(8'h65, 9'h03c, 13'h0, 32'h0e);
    rd_chk(ASP_OFS_IREQ, 32'h2);
    rx(8'h65, 9'h05a, 13'h0, 32'h9e);
    rd_chk(ASP_OFS_RBUF, 32'h5a);
    rd_chk(ASP_OFS_CTL1, 32'h06);
    rx(8'h65, 9'h05a, 13'h200, 32'hce);
    wb(1'b0, ASP_OFS_RBUF, 32'h0);
    rx(8'h65, 9'h05a, 13'h400, 32'hae);
    wb(1'b0, ASP_OFS_RBUF, 32'h0);
    wb(1'b1, ASP_OFS_MODE, 32'he5);
    rx(8'he5, 9'h012, 13'h0, 32'h06);
    rx(8'he5, 9'h092, 13'h0, 32'h0e);
    wb(1'b1, ASP_OFS_CTL1, 32'h0);
    rd_chk(ASP_OFS_CTL1, 32'h02);
    rd_chk(ASP_OFS_RBUF, 32'h92);
    end_of_test();
  end
endmodule
